// *** src/rso_pkg.sv ***
// rso_pkg: opcodes, widths and reset values for the return-stack execution block
// assumes: 16-bit instruction words, byte-addressed program counter
package rso_pkg;
    localparam int PC_W              = 21;
    localparam int OP_W              = 16;
    localparam int OFS_W             = 11;
    localparam int DEPTH_DEF         = 31;
    localparam logic [OP_W-1:0] OP_POP_TOP   = 16'h0006;
    localparam logic [OP_W-1:0] OP_PUSH_NEXT = 16'h0005;
    localparam logic [OP_W-1:0] OP_SOFT_RST  = 16'h00ff;
    localparam logic [4:0]      CALL_HI      = 5'h1b;
    localparam int              CALL_HI_LSB  = 11;
    localparam logic [PC_W-1:0] PC_STEP      = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET     = 21'h000000;
    localparam logic [PC_W-1:0] ENTRY_RESET  = 21'h000000;

    typedef enum logic [1:0] {
        RSO_EXEC = 2'b00,
        RSO_SKIP = 2'b01
    } rso_state_e;
endpackage

// *** src/rso_stack_if.sv ***
// rso_stack_if: push/pop/write port between the decoder and the stack store
// assumes: single clock, one operation per cycle
`timescale 1ns/1ps
interface rso_stack_if
    import rso_pkg::*;
();
    logic            push;
    logic            pop;
    logic            wr_top;
    logic [PC_W-1:0] push_val;
    logic [PC_W-1:0] wr_val;
    logic [PC_W-1:0] top;
    logic [PC_W-1:0] below;

    modport ctrl  (output push, pop, wr_top, push_val, wr_val, input top, below);
    modport store (input push, pop, wr_top, push_val, wr_val, output top, below);
endinterface

// *** src/rso_stack.sv ***
// rso_stack: fixed-depth lifo of program addresses
// assumes: controller never pushes and pops in one cycle; overflow drops the deepest entry
`timescale 1ns/1ps
module rso_stack
    import rso_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
)(
    input  wire logic    i_clk,
    input  wire logic    i_srst,
    rso_stack_if.store   s
);
    logic [PC_W-1:0] mem_reg    [DEPTH];
    logic [PC_W-1:0] mem_next   [DEPTH];
    logic [PC_W-1:0] from_above [DEPTH];
    logic [PC_W-1:0] from_below [DEPTH];

    // neighbour links; the ends take the new value and the empty fill
    assign from_above[0]       = s.push_val;
    assign from_below[DEPTH-1] = ENTRY_RESET;

    for (genvar g = 1; g < DEPTH; g++)
    begin : g_link
        assign from_above[g]   = mem_reg[g-1];
        assign from_below[g-1] = mem_reg[g];
    end

    always_comb
    begin
        for (int k = 0; k < DEPTH; k++)
        begin
            mem_next[k] = mem_reg[k];
            if (s.push)
                mem_next[k] = from_above[k];
            else if (s.pop)
                mem_next[k] = from_below[k];
            else if (s.wr_top && k == 0)
                mem_next[k] = s.wr_val;
        end
    end

    always_ff @(posedge i_clk)
    begin
        for (int k = 0; k < DEPTH; k++)
        begin
            if (i_srst)
                mem_reg[k] <= ENTRY_RESET;
            else
                mem_reg[k] <= mem_next[k];
        end
    end

    assign s.top   = mem_reg[0];
    assign s.below = mem_reg[1];
endmodule

// *** src/rso_core.sv ***
// rso_core: executes pop, push, relative call and software reset on the return stack
// assumes: one instruction per clock; i_pc is address of the current instruction
`timescale 1ns/1ps
module rso_core
    import rso_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
)(
    input  wire logic            i_clk,
    input  wire logic            i_srst,
    input  wire logic            i_master_clear_reset,
    input  wire logic            i_valid,
    input  wire logic [OP_W-1:0] i_opcode,
    input  wire logic [PC_W-1:0] i_pc,
    input  wire logic            i_top_wr,
    input  wire logic [PC_W-1:0] i_top_wr_val,
    output logic [PC_W-1:0]      o_stack_top_entry,
    output logic                 o_pc_load,
    output logic [PC_W-1:0]      o_pc_target,
    output logic                 o_busy,
    output logic                 o_core_reset
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_relative_call(input logic [OP_W-1:0] op);
        return op[OP_W-1:CALL_HI_LSB] == CALL_HI;
    endfunction

    // exact match of a single-word opcode
    function automatic logic is_word(input logic [OP_W-1:0] op, input logic [OP_W-1:0] code);
        return op == code;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // master clear pin: two flops before anything reads it
    logic mc_s1_reg;
    logic mc_s2_reg;
    logic rst_all;

    always_ff @(posedge i_clk)
    begin
        mc_s1_reg <= i_master_clear_reset;
        mc_s2_reg <= mc_s1_reg;
    end

    // software reset reuses the master clear path
    assign rst_all = i_srst | mc_s2_reg | o_core_reset;

    ////////////////////////////////////////////////////////////////////////
    rso_stack_if stk ();

    rso_stack #(
        .DEPTH (DEPTH)
    ) u_stack (
        .i_clk  (i_clk),
        .i_srst (rst_all),
        .s      (stk.store)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode
    rso_state_e      state_reg;
    rso_state_e      state_next;
    logic            load_next;
    logic            rst_next;
    logic            busy_next;
    logic [PC_W-1:0] tgt_next;
    logic            go;
    logic            pop_op;
    logic            push_op;
    logic            call_op;
    logic            rst_op;
    logic [PC_W-1:0] ret_addr;
    logic [PC_W-1:0] ofs_ext;
    logic [PC_W-1:0] call_tgt;

    // nothing is taken in the dead cycle after a call or while any reset is active
    assign go       = i_valid && state_reg == RSO_EXEC && !rst_all;
    assign pop_op   = go && is_word(i_opcode, OP_POP_TOP);
    assign push_op  = go && is_word(i_opcode, OP_PUSH_NEXT);
    assign call_op  = go && is_relative_call(i_opcode);
    assign rst_op   = go && is_word(i_opcode, OP_SOFT_RST);
    assign ret_addr = i_pc + PC_STEP;
    // sign-extended word offset, doubled to a byte distance
    assign ofs_ext  = PC_W'({{(PC_W-OFS_W){i_opcode[OFS_W-1]}}, i_opcode[OFS_W-1:0]} << 1);
    assign call_tgt = ret_addr + ofs_ext;

    ////////////////////////////////////////////////////////////////////////
    // stack port: return address goes in before the pc moves
    assign stk.push     = push_op || call_op;
    assign stk.pop      = pop_op;
    assign stk.push_val = ret_addr;
    // top write loses to push and pop in the same cycle
    assign stk.wr_top   = i_top_wr && !stk.push && !stk.pop;
    assign stk.wr_val   = i_top_wr_val;

    ////////////////////////////////////////////////////////////////////////
    // sequencing and pc load
    always_comb
    begin
        state_next = RSO_EXEC;
        load_next  = 1'b0;
        tgt_next   = o_pc_target;
        rst_next   = rst_op;
        busy_next  = call_op;
        if (o_core_reset)
            tgt_next = PC_RESET;
        else if (call_op)
        begin
            state_next = RSO_SKIP;
            load_next  = 1'b1;
            tgt_next   = call_tgt;
        end
        case (state_reg)
            RSO_EXEC: ;
            RSO_SKIP: state_next = RSO_EXEC;
            default:  state_next = RSO_EXEC;
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst || mc_s2_reg)
        begin
            state_reg    <= RSO_EXEC;
            o_pc_load    <= 1'b0;
            o_pc_target  <= PC_RESET;
            o_core_reset <= 1'b0;
            o_busy       <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            o_pc_load    <= load_next;
            o_pc_target  <= tgt_next;
            o_core_reset <= rst_next;
            o_busy       <= busy_next;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_stack_top_entry <= ENTRY_RESET;
        else
            o_stack_top_entry <= stk.top;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence seq_call;
        call_op ##1 (o_pc_load && state_reg == RSO_SKIP);
    endsequence

    sequence seq_call_pulse;
        (o_pc_load && o_busy) ##1 (!o_pc_load && !o_busy);
    endsequence

    sequence seq_soft_clear;
        o_core_reset ##1 (!o_core_reset && state_reg == RSO_EXEC && !o_pc_load && !o_busy);
    endsequence

    AST_CALL_TWO: assert property (@(posedge i_clk) disable iff (i_srst)
        seq_call |=> (state_reg == RSO_EXEC && !o_pc_load))
        else $error("call not two cycles");

    AST_CALL_TGT: assert property (@(posedge i_clk) disable iff (i_srst)
        call_op |=> o_pc_target == $past(call_tgt))
        else $error("call target wrong");

    AST_CALL_PUSH: assert property (@(posedge i_clk) disable iff (i_srst || mc_s2_reg)
        call_op |=> stk.top == $past(ret_addr))
        else $error("call return address missing");

    AST_PUSH_VAL: assert property (@(posedge i_clk) disable iff (i_srst || mc_s2_reg)
        push_op |=> stk.top == $past(ret_addr))
        else $error("push value wrong");

    AST_PUSH_DOWN: assert property (@(posedge i_clk) disable iff (i_srst || mc_s2_reg)
        push_op |=> stk.below == $past(stk.top))
        else $error("push lost old top");

    AST_POP_UP: assert property (@(posedge i_clk) disable iff (i_srst || mc_s2_reg)
        pop_op |=> stk.top == $past(stk.below))
        else $error("pop did not move up");

    AST_POP_ONE: assert property (@(posedge i_clk) disable iff (i_srst)
        pop_op |=> !o_busy && !o_pc_load)
        else $error("pop took extra cycle");

    AST_TOP_WR: assert property (@(posedge i_clk) disable iff (i_srst || mc_s2_reg)
        (stk.wr_top && !rst_all) |=> stk.top == $past(i_top_wr_val))
        else $error("top write lost");

    AST_SOFT_RST: assert property (@(posedge i_clk) disable iff (i_srst || mc_s2_reg)
        rst_op |=> o_core_reset ##1 (!o_core_reset && stk.top == ENTRY_RESET && o_pc_target == PC_RESET))
        else $error("soft reset wrong");

    AST_MASTER_CLR: assert property (@(posedge i_clk) disable iff (i_srst)
        mc_s2_reg |=> (stk.top == ENTRY_RESET && state_reg == RSO_EXEC && !o_core_reset))
        else $error("master clear incomplete");

    AST_CALL_PULSE: assert property (@(posedge i_clk) disable iff (i_srst || mc_s2_reg)
        call_op |=> seq_call_pulse)
        else $error("call load or busy not one cycle");

    AST_SOFT_CLEAR: assert property (@(posedge i_clk) disable iff (i_srst || mc_s2_reg)
        rst_op |=> seq_soft_clear)
        else $error("soft reset left state behind");

    AST_PUSH_ONE: assert property (@(posedge i_clk) disable iff (i_srst)
        push_op |=> (!o_pc_load && !o_busy && state_reg == RSO_EXEC))
        else $error("push took extra cycle");

    AST_STACK_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
        (!stk.push && !stk.pop && !stk.wr_top && !rst_all) |=> stk.top == $past(stk.top))
        else $error("stack top moved without an operation");

    AST_TGT_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
        (!call_op && !rst_all) |=> o_pc_target == $past(o_pc_target))
        else $error("pc target moved without a call");

    AST_TOP_OUT: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_srst |=> o_stack_top_entry == $past(stk.top))
        else $error("top output does not follow the stack");

    AST_SKIP_REFUSE: assert property (@(posedge i_clk) disable iff (i_srst)
        (state_reg == RSO_SKIP) |-> (!stk.push && !stk.pop && !o_core_reset))
        else $error("instruction taken in dead cycle");
endmodule

// *** testbench/rso_core_tb.sv ***
// rso_core_tb: directed bench for the return-stack execution block
// assumes: inputs change on the falling edge, outputs settle before it
`timescale 1ns/1ps
module rso_core_tb;
    import rso_pkg::*;
    logic            i_clk = 1'b0;
    logic            i_srst = 1'b1;
    logic            i_master_clear_reset = 1'b0;
    logic            i_valid = 1'b0;
    logic [OP_W-1:0] i_opcode = 16'h0000;
    logic [PC_W-1:0] i_pc = 21'h000000;
    logic            i_top_wr = 1'b0;
    logic [PC_W-1:0] i_top_wr_val = 21'h000000;
    logic [PC_W-1:0] o_stack_top_entry;
    logic            o_pc_load;
    logic [PC_W-1:0] o_pc_target;
    logic            o_busy;
    logic            o_core_reset;
    int              n_fail = 0;
    int              total_checks = 0;
    always #5 i_clk = ~i_clk;
    rso_core #(.DEPTH(4)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_master_clear_reset(i_master_clear_reset),
        .i_valid(i_valid), .i_opcode(i_opcode), .i_pc(i_pc), .i_top_wr(i_top_wr), .i_top_wr_val(i_top_wr_val),
        .o_stack_top_entry(o_stack_top_entry), .o_pc_load(o_pc_load), .o_pc_target(o_pc_target),
        .o_busy(o_busy), .o_core_reset(o_core_reset));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [PC_W-1:0] exp, input logic [PC_W-1:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // drive one word, return two cycles later
    task automatic run_op(input logic [OP_W-1:0] op, input logic [PC_W-1:0] pc);
        i_valid = 1'b1;
        i_opcode = op;
        i_pc = pc;
        @(negedge i_clk);
        i_valid = 1'b0;
        @(negedge i_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic push_pop();
        run_op(OP_PUSH_NEXT, 21'h000124);
        chk("top", 21'h000126, o_stack_top_entry);
        run_op(OP_PUSH_NEXT, 21'h000200);
        chk("top", 21'h000202, o_stack_top_entry);
        run_op(OP_POP_TOP, 21'h000300);
        chk("top", 21'h000126, o_stack_top_entry);
    endtask
    task automatic top_write();
        i_top_wr = 1'b1;
        i_top_wr_val = 21'h00345a;
        @(negedge i_clk);
        i_top_wr = 1'b0;
        @(negedge i_clk);
        chk("top", 21'h00345a, o_stack_top_entry);
        run_op(OP_PUSH_NEXT, 21'h000124);
        run_op(OP_POP_TOP, 21'h000000);
        chk("top", 21'h00345a, o_stack_top_entry);
    endtask
    task automatic call(input logic [OP_W-1:0] op, input logic [PC_W-1:0] pc, input logic [PC_W-1:0] tgt);
        i_valid = 1'b1;
        i_opcode = op;
        i_pc = pc;
        @(negedge i_clk);
        chk("load", 21'h000001, {20'h00000, o_pc_load});
        chk("busy", 21'h000001, {20'h00000, o_busy});
        chk("target", tgt, o_pc_target);
        i_opcode = OP_PUSH_NEXT;
        @(negedge i_clk);
        i_valid = 1'b0;
        chk("load", 21'h000000, {20'h00000, o_pc_load});
        chk("top", pc + 21'h000002, o_stack_top_entry);
        @(negedge i_clk);
        chk("top", pc + 21'h000002, o_stack_top_entry);
    endtask
    task automatic soft_reset();
        i_valid = 1'b1;
        i_opcode = OP_SOFT_RST;
        @(negedge i_clk);
        i_valid = 1'b0;
        chk("core_reset", 21'h000001, {20'h00000, o_core_reset});
        repeat (2) @(negedge i_clk);
        chk("core_reset", 21'h000000, {20'h00000, o_core_reset});
        chk("top", 21'h000000, o_stack_top_entry);
        chk("target", 21'h000000, o_pc_target);
    endtask
    task automatic master_clear();
        call(16'hd805, 21'h000100, 21'h00010c);
        run_op(OP_PUSH_NEXT, 21'h000040);
        i_master_clear_reset = 1'b1;
        repeat (4) @(negedge i_clk);
        i_master_clear_reset = 1'b0;
        repeat (4) @(negedge i_clk);
        chk("top", 21'h000000, o_stack_top_entry);
        chk("target", 21'h000000, o_pc_target);
    endtask
    task automatic depth_limit();
        for (int k = 1; k <= 5; k++)
            run_op(OP_PUSH_NEXT, 21'(k * 16));
        for (int k = 4; k >= 1; k--)
        begin
            run_op(OP_POP_TOP, 21'h000000);
            chk("top", (k > 1) ? 21'(k * 16 + 2) : 21'h000000, o_stack_top_entry);
        end
    endtask
    task automatic sync_reset();
        run_op(OP_PUSH_NEXT, 21'h000080);
        chk("top", 21'h000082, o_stack_top_entry);
        i_srst = 1'b1;
        @(negedge i_clk);
        i_srst = 1'b0;
        chk("top", 21'h000000, o_stack_top_entry);
        run_op(OP_PUSH_NEXT, 21'h000090);
        chk("top", 21'h000092, o_stack_top_entry);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(negedge i_clk);
        i_srst = 1'b0;
        @(negedge i_clk);
        push_pop();
        top_write();
        call(16'hd805, 21'h000100, 21'h00010c);
        call(16'hdc00, 21'h001000, 21'h000802);
        call(16'hdbff, 21'h000100, 21'h000900);
        soft_reset();
        master_clear();
        depth_limit();
        sync_reset();
        print_verdict();
    end
    initial
    begin
        repeat (2000) @(posedge i_clk);
        n_fail++;
        print_verdict();
    end
endmodule
